/* verilog/bus_parity_error_logger.sv */
// Data bus parity checker and error logger with AXI4-Lite register access
//
// Local design decision: the AXI4-Lite interface to the registers.
module bus_parity_error_logger
  import parity_logger_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Processor bus address tenure
  input  wire logic                tsN,
  input  wire logic [31:0]         busAddr,
  input  wire logic [TT_WIDTH-1:0] busTt,
  input  wire logic                addrHit,
  input  wire logic                busWrite,
  // Processor bus data tenure
  input  wire logic                taN,
  input  wire logic                artryN,
  input  wire logic [31:0]         dataHigh,
  input  wire logic [31:0]         dataLow,
  input  wire logic [LANES-1:0]    dpIn,
  // Read data the device is about to drive
  input  wire logic                readDrive,
  input  wire logic [63:0]         readData,
  // Parity pins driven by the device
  output logic      [LANES-1:0]    dpOut,
  output logic                     dpOe,
  // Error signalling
  output logic                     machineCheckReqN,
  output logic                     irq,
  // AXI4-Lite write address
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         awaddr,
  // AXI4-Lite write data
  input  wire logic                wvalid,
  output logic                     wready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  // AXI4-Lite write response
  output logic                     bvalid,
  input  wire logic                bready,
  output logic      [1:0]          bresp,
  // AXI4-Lite read address
  input  wire logic                arvalid,
  output logic                     arready,
  input  wire logic [31:0]         araddr,
  // AXI4-Lite read data
  output logic                     rvalid,
  input  wire logic                rready,
  output logic      [31:0]         rdata,
  output logic      [1:0]          rresp
);

  // Bus side state
  tenure_t             tenure_r;
  dataBeat_t           beat;
  logic [LANES-1:0]    checkPar;
  logic [LANES-1:0]    drivePar;
  logic [LANES-1:0]    laneErr;
  logic                checkCycle;
  logic                parityErr;
  logic                logRise;

  // Logged error state
  logic                logged_r;
  logic [31:0]         errAddr_r;
  logic [31:0]         errUpper_r;
  logic [31:0]         errLower_r;
  logic [TT_WIDTH-1:0] errTt_r;
  logic [LANES-1:0]    errPar_r;

  // Control state
  logic                ckall_r;
  logic                mchkEnable_r;
  logic [LANES-1:0]    invert_r;

  // Pin outputs
  logic [LANES-1:0]    dpOut_r;
  logic                dpOe_r;
  logic                mchkN_r;

  // AXI state
  logic                awReady_r;
  logic                awHeld_r;
  logic [31:0]         awAddr_r;
  logic                wReady_r;
  logic                wHeld_r;
  logic [31:0]         wData_r;
  logic [3:0]          wStrb_r;
  logic                bValid_r;
  logic [1:0]          bResp_r;
  logic                arReady_r;
  logic                rValid_r;
  logic [31:0]         rData_r;
  logic [1:0]          rResp_r;

  // Register file access decode
  logic                writeGo;
  regSel_t             wSel;
  regSel_t             rSel;
  logic [31:0]         controlWord;
  logic [31:0]         controlNew;
  logic [31:0]         clearWord;
  logic [31:0]         enableWord;
  logic                clearLogged;
  logic [IRQ_W-1:0]    irqEvents;
  logic [IRQ_W-1:0]    irqClear;
  logic                irqEnableWrite;
  logic [IRQ_W-1:0]    irqStatus;
  logic [IRQ_W-1:0]    irqEnable;
  logic                irqLine;

  // ---------------------------------------------------------------
  // Parity check
  // ---------------------------------------------------------------

  // The tenure is held until the next start strobe; a pipelined bus that
  // starts a new address tenure before the data tenure ends would need a queue
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tenure_r <= '0;
    end else if (!tsN) begin
      tenure_r <= '{addr: busAddr, tt: busTt, hit: addrHit, write: busWrite};
    end
  end

  assign beat = '{upper: dataHigh, lower: dataLow, par: dpIn};

  lane_parity uCheckParity (
    .data   ({beat.upper, beat.lower}),
    .oddPar (checkPar)
  );

  assign laneErr = checkPar ^ beat.par;

  always_comb begin
    checkCycle = 1'b0;
    if (!taN && artryN) begin
      if (ckall_r) begin
        checkCycle = 1'b1;
      end else begin
        checkCycle = tenure_r.hit && tenure_r.write;
      end
    end
  end

  assign parityErr = checkCycle && (|laneErr);
  assign logRise   = parityErr && !logged_r;

  // Set wins over a clear written in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      logged_r <= 1'b0;
    end else if (parityErr) begin
      logged_r <= 1'b1;
    end else if (clearLogged) begin
      logged_r <= 1'b0;
    end
  end

  // Captures hold the first error until software clears the flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      errAddr_r  <= RESET_CAPTURE;
      errUpper_r <= RESET_CAPTURE;
      errLower_r <= RESET_CAPTURE;
      errTt_r    <= RESET_TT;
      errPar_r   <= RESET_INVERT;
    end else if (logRise) begin
      errAddr_r  <= tenure_r.addr;
      errUpper_r <= beat.upper;
      errLower_r <= beat.lower;
      errTt_r    <= tenure_r.tt;
      errPar_r   <= beat.par;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mchkN_r <= 1'b1;
    end else begin
      mchkN_r <= !(logRise && mchkEnable_r);
    end
  end

  // ---------------------------------------------------------------
  // Parity driven on device reads
  // ---------------------------------------------------------------

  lane_parity uDriveParity (
    .data   (readData),
    .oddPar (drivePar)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dpOut_r <= '0;
      dpOe_r  <= 1'b0;
    end else begin
      dpOut_r <= drivePar ^ invert_r;
      dpOe_r  <= readDrive;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------

  assign irqEvents[IRQ_LOGGED]  = logRise;
  assign irqEvents[IRQ_OVERRUN] = parityErr && logged_r;

  irq_sticky uIrq (
    .clk         (clk),
    .reset       (reset),
    .events      (irqEvents),
    .clearBits   (irqClear),
    .enableWrite (irqEnableWrite),
    .enableData  (enableWord[IRQ_W-1:0]),
    .status      (irqStatus),
    .enable      (irqEnable),
    .irq         (irqLine)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------

  // Ready drops after each handshake and returns once the response is accepted,
  // so only one write is ever held
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awReady_r <= 1'b1;
      awHeld_r  <= 1'b0;
      awAddr_r  <= '0;
    end else if (awvalid && awReady_r) begin
      awReady_r <= 1'b0;
      awHeld_r  <= 1'b1;
      awAddr_r  <= awaddr;
    end else if (writeGo) begin
      awHeld_r  <= 1'b0;
    end else if (bValid_r && bready) begin
      awReady_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wReady_r <= 1'b1;
      wHeld_r  <= 1'b0;
      wData_r  <= '0;
      wStrb_r  <= '0;
    end else if (wvalid && wReady_r) begin
      wReady_r <= 1'b0;
      wHeld_r  <= 1'b1;
      wData_r  <= wdata;
      wStrb_r  <= wstrb;
    end else if (writeGo) begin
      wHeld_r  <= 1'b0;
    end else if (bValid_r && bready) begin
      wReady_r <= 1'b1;
    end
  end

  assign writeGo = awHeld_r && wHeld_r;
  assign wSel    = decodeReg(awAddr_r);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bValid_r <= 1'b0;
      bResp_r  <= RESP_OKAY;
    end else if (writeGo) begin
      bValid_r <= 1'b1;
      unique case (wSel)
        SEL_CONTROL, SEL_IRQ_CLEAR, SEL_IRQ_ENABLE: bResp_r <= RESP_OKAY;
        SEL_NONE:                                   bResp_r <= RESP_DECERR;
        default:                                    bResp_r <= RESP_SLVERR;
      endcase
    end else if (bValid_r && bready) begin
      bValid_r <= 1'b0;
    end
  end

  assign controlNew = mergeStrb(controlWord, wData_r, wStrb_r);
  assign clearWord  = mergeStrb(32'h00000000, wData_r, wStrb_r);
  assign enableWord = mergeStrb({{(32-IRQ_W){1'b0}}, irqEnable}, wData_r, wStrb_r);

  // Logged flag is write-one-to-clear through the control register
  assign clearLogged    = writeGo && (wSel == SEL_CONTROL) && clearWord[CTL_LOGGED_BIT];
  assign irqClear       = (writeGo && (wSel == SEL_IRQ_CLEAR)) ? clearWord[IRQ_W-1:0] : RESET_IRQ;
  assign irqEnableWrite = writeGo && (wSel == SEL_IRQ_ENABLE);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ckall_r      <= 1'b0;
      mchkEnable_r <= 1'b0;
      invert_r     <= RESET_INVERT;
    end else if (writeGo && (wSel == SEL_CONTROL)) begin
      ckall_r      <= controlNew[CTL_CKALL_BIT];
      mchkEnable_r <= controlNew[CTL_ME_BIT];
      invert_r     <= controlNew[CTL_INV_LSB +: LANES];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------

  always_comb begin
    controlWord = 32'h00000000;
    controlWord[CTL_LOGGED_BIT]           = logged_r;
    controlWord[CTL_TT_LSB +: TT_WIDTH]   = errTt_r;
    controlWord[CTL_DP_LSB +: LANES]      = errPar_r;
    controlWord[CTL_CKALL_BIT]            = ckall_r;
    controlWord[CTL_ME_BIT]               = mchkEnable_r;
    controlWord[CTL_INV_LSB +: LANES]     = invert_r;
  end

  assign rSel = decodeReg(araddr);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      arReady_r <= 1'b1;
      rValid_r  <= 1'b0;
      rData_r   <= '0;
      rResp_r   <= RESP_OKAY;
    end else if (arvalid && arReady_r) begin
      arReady_r <= 1'b0;
      rValid_r  <= 1'b1;
      rResp_r   <= (rSel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
      unique case (rSel)
        SEL_CONTROL:    rData_r <= controlWord;
        SEL_ERR_ADDR:   rData_r <= errAddr_r;
        SEL_ERR_UPPER:  rData_r <= errUpper_r;
        SEL_ERR_LOWER:  rData_r <= errLower_r;
        SEL_IRQ_STATUS: rData_r <= {{(32-IRQ_W){1'b0}}, irqStatus};
        SEL_IRQ_ENABLE: rData_r <= {{(32-IRQ_W){1'b0}}, irqEnable};
        SEL_IRQ_CLEAR:  rData_r <= 32'h00000000;
        SEL_NONE:       rData_r <= 32'h00000000;
      endcase
    end else if (rValid_r && rready) begin
      rValid_r  <= 1'b0;
      arReady_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  assign dpOut            = dpOut_r;
  assign dpOe             = dpOe_r;
  assign machineCheckReqN = mchkN_r;
  assign irq              = irqLine;
  assign awready          = awReady_r;
  assign wready           = wReady_r;
  assign bvalid           = bValid_r;
  assign bresp            = bResp_r;
  assign arready          = arReady_r;
  assign rvalid           = rValid_r;
  assign rdata            = rData_r;
  assign rresp            = rResp_r;

endmodule // bus_parity_error_logger

/* verilog/parity_logger_pkg.sv */
// Register map, field layout, reset values and carrier types of the parity error logger
package parity_logger_pkg;

  localparam int LANES    = 8;
  localparam int TT_WIDTH = 5;
  localparam int IRQ_W    = 2;

  // Register byte addresses
  localparam logic [31:0] ADDR_CONTROL    = 32'hFEF80068;
  localparam logic [31:0] ADDR_ERR_ADDR   = 32'hFEF80070;
  localparam logic [31:0] ADDR_ERR_UPPER  = 32'hFEF80078;
  localparam logic [31:0] ADDR_ERR_LOWER  = 32'hFEF80080;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'hFEF80084;
  localparam logic [31:0] ADDR_IRQ_CLEAR  = 32'hFEF80088;
  localparam logic [31:0] ADDR_IRQ_ENABLE = 32'hFEF8008C;

  // Control register field positions
  localparam int CTL_LOGGED_BIT = 31;
  localparam int CTL_TT_LSB     = 24;
  localparam int CTL_DP_LSB     = 16;
  localparam int CTL_CKALL_BIT  = 9;
  localparam int CTL_ME_BIT     = 8;
  localparam int CTL_INV_LSB    = 0;

  // Interrupt status bit positions
  localparam int IRQ_LOGGED  = 0;
  localparam int IRQ_OVERRUN = 1;

  // Reset values
  localparam logic [31:0]       RESET_CAPTURE = 32'h00000000;
  localparam logic [LANES-1:0]  RESET_INVERT  = 8'h00;
  localparam logic [TT_WIDTH-1:0] RESET_TT    = 5'h00;
  localparam logic [IRQ_W-1:0]  RESET_IRQ     = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum {
    SEL_NONE, SEL_CONTROL, SEL_ERR_ADDR, SEL_ERR_UPPER,
    SEL_ERR_LOWER, SEL_IRQ_STATUS, SEL_IRQ_CLEAR, SEL_IRQ_ENABLE
  } regSel_t;

  // Address tenure as latched at the start strobe
  typedef struct packed {
    logic [31:0]         addr;
    logic [TT_WIDTH-1:0] tt;
    logic                hit;
    logic                write;
  } tenure_t;

  // One data beat as seen on the bus
  typedef struct packed {
    logic [31:0]      upper;
    logic [31:0]      lower;
    logic [LANES-1:0] par;
  } dataBeat_t;

  function automatic regSel_t decodeReg(input logic [31:0] a);
    unique case (a)
      ADDR_CONTROL:    decodeReg = SEL_CONTROL;
      ADDR_ERR_ADDR:   decodeReg = SEL_ERR_ADDR;
      ADDR_ERR_UPPER:  decodeReg = SEL_ERR_UPPER;
      ADDR_ERR_LOWER:  decodeReg = SEL_ERR_LOWER;
      ADDR_IRQ_STATUS: decodeReg = SEL_IRQ_STATUS;
      ADDR_IRQ_CLEAR:  decodeReg = SEL_IRQ_CLEAR;
      ADDR_IRQ_ENABLE: decodeReg = SEL_IRQ_ENABLE;
      default:         decodeReg = SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    mergeStrb = r;
  endfunction

endpackage

/* verilog/lane_parity.sv */
// Odd parity per byte lane of the 64-bit data bus, lane 0 on the most significant byte
module lane_parity
  import parity_logger_pkg::*;
(
  // Data
  input  wire logic [63:0]      data,
  // Parity bit that makes each lane odd
  output logic      [LANES-1:0] oddPar
);

  genvar k;
  generate
    for (k = 0; k < LANES; k++) begin : gLane
      assign oddPar[k] = ~(^data[63-8*k -: 8]);
    end
  endgenerate

endmodule // lane_parity

/* verilog/irq_sticky.sv */
// Sticky interrupt status with write-one-to-clear, enable mask and level output
module irq_sticky
  import parity_logger_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Events and software access
  input  wire logic [IRQ_W-1:0] events,
  input  wire logic [IRQ_W-1:0] clearBits,
  input  wire logic             enableWrite,
  input  wire logic [IRQ_W-1:0] enableData,
  // State
  output logic      [IRQ_W-1:0] status,
  output logic      [IRQ_W-1:0] enable,
  output logic                  irq
);

  logic [IRQ_W-1:0] status_r;
  logic [IRQ_W-1:0] enable_r;
  logic             irq_r;
  logic [IRQ_W-1:0] status_nxt;

  // An event in the clearing cycle survives the clear
  assign status_nxt = (status_r & ~clearBits) | events;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_r <= RESET_IRQ;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_r <= RESET_IRQ;
    end else if (enableWrite) begin
      enable_r <= enableData;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & (enableWrite ? enableData : enable_r));
    end
  end

  assign status = status_r;
  assign enable = enable_r;
  assign irq    = irq_r;

endmodule // irq_sticky

/* verification/parity_logger_monitor.sv */
// Concurrent checks on the parity logger's ports
module parity_logger_monitor
  import parity_logger_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Bus side
  input wire logic        taN,
  input wire logic        artryN,
  input wire logic        readDrive,
  input wire logic        dpOe,
  input wire logic        machineCheckReqN,
  // AXI4-Lite
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] araddr,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_OE_FOLLOWS: assert property (readDrive |=> dpOe)
    else $error("parity drive enable missed a read cycle");
  AST_OE_IDLE: assert property (!readDrive |=> !dpOe)
    else $error("parity driven outside a read");
  AST_MCHK_ONE: assert property ($fell(machineCheckReqN) |=> machineCheckReqN)
    else $error("machine check request longer than one cycle");
  AST_MCHK_CAUSE: assert property ($fell(machineCheckReqN) |-> $past(!taN && artryN))
    else $error("machine check request without a checked beat");
  AST_RETRY_SKIP: assert property (!taN && !artryN |=> machineCheckReqN)
    else $error("retried beat raised machine check");
  AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not one cycle after address");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  AST_UNMAPPED: assert property (arvalid && arready && araddr[1:0] != 2'h0 |=> rresp == RESP_DECERR && rdata == 32'h0)
    else $error("unaligned read not decode error");
  COV_MCHK: cover property ($fell(machineCheckReqN));
  COV_RETRY: cover property (!taN && !artryN);
  COV_DECERR: cover property (rvalid && rresp == RESP_DECERR);
endmodule // parity_logger_monitor

bind bus_parity_error_logger parity_logger_monitor mon (.clk(clk), .reset(reset), .taN(taN), .artryN(artryN),
  .readDrive(readDrive), .dpOe(dpOe), .machineCheckReqN(machineCheckReqN), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rdata(rdata),
  .rresp(rresp));

/* verification/bus_master_model.sv */
// Processor-side bus master that runs address tenures and data beats
module bus_master_model
  import parity_logger_pkg::*;
(
  // Clock
  input  wire logic                clk,
  // Address tenure
  output logic                     tsN,
  output logic      [31:0]         busAddr,
  output logic      [TT_WIDTH-1:0] busTt,
  output logic                     addrHit,
  output logic                     busWrite,
  // Data tenure
  output logic                     taN,
  output logic                     artryN,
  output logic      [31:0]         dataHigh,
  output logic      [31:0]         dataLow,
  output logic      [LANES-1:0]    dpIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {tsN, taN, artryN} = 3'h7;
    {busAddr, busTt, addrHit, busWrite, dataHigh, dataLow, dpIn} = '0;
  end
  function automatic logic [LANES-1:0] goodPar(input logic [63:0] d);
    for (int k = 0; k < LANES; k++) begin
      goodPar[k] = ~^d[63-8*k -: 8];
    end
  endfunction
  task automatic tenure(input logic [31:0] a, input logic [TT_WIDTH-1:0] t, input logic hit, input logic wr);
    @(posedge clk);
    tsN <= 1'b0;
    {busAddr, busTt, addrHit, busWrite} <= {a, t, hit, wr};
    @(posedge clk);
    tsN <= 1'b1;
    // Released address and type lines show the inverse so a stale value is never mistaken for a live one
    {busAddr, busTt} <= ~{a, t};
  endtask
  // Flip marks lanes given wrong parity; retry asserts the qualified retry with the acknowledge
  task automatic beat(input logic [63:0] d, input logic [LANES-1:0] flip, input logic retry);
    @(posedge clk);
    taN <= 1'b0;
    artryN <= ~retry;
    {dataHigh, dataLow, dpIn} <= {d, goodPar(d) ^ flip};
    @(posedge clk);
    {taN, artryN} <= 2'h3;
    {dataHigh, dataLow, dpIn} <= ~{d, goodPar(d) ^ flip};
  endtask
endmodule // bus_master_model

/* verification/testbench.sv */
// Self-checking bench for the bus parity error logger
module testbench
  import parity_logger_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] UNMAPPED = 32'hFEF80071;
  localparam logic [63:0] D1 = 64'h0123456789ABCDEF, D2 = 64'hFEDCBA9876543210, D3 = 64'h00FF00FF5A5AA5A5;
  logic clk = 1'b0, reset = 1'b1, readDrive = 1'b0;
  logic [63:0] readData = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0] wstrb = 4'hF;
  logic tsN, addrHit, busWrite, taN, artryN, dpOe, machineCheckReqN, irq, awready, wready, bvalid, arready, rvalid;
  logic [31:0] busAddr, dataHigh, dataLow, rdata;
  logic [TT_WIDTH-1:0] busTt;
  logic [LANES-1:0] dpIn, dpOut;
  logic [1:0] bresp, rresp;
  int bad_count = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  bus_master_model cpu (.clk(clk), .tsN(tsN), .busAddr(busAddr), .busTt(busTt), .addrHit(addrHit),
    .busWrite(busWrite), .taN(taN), .artryN(artryN), .dataHigh(dataHigh), .dataLow(dataLow), .dpIn(dpIn));
  bus_parity_error_logger dut (.clk(clk), .reset(reset), .tsN(tsN), .busAddr(busAddr), .busTt(busTt),
    .addrHit(addrHit), .busWrite(busWrite), .taN(taN), .artryN(artryN), .dataHigh(dataHigh), .dataLow(dataLow),
    .dpIn(dpIn), .readDrive(readDrive), .readData(readData), .dpOut(dpOut), .dpOe(dpOe),
    .machineCheckReqN(machineCheckReqN), .irq(irq), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk);
    {awvalid, wvalid, awaddr, wdata} <= {2'h3, a, d};
    while (aw || w) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    // Slow master: bready only after the response shows, so the response must stand
    while (!bvalid) @(posedge clk);
    bready <= 1'b1;
    @(posedge clk);
    chk({30'h0, bresp}, {30'h0, er}, "write response");
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    {arvalid, araddr, rready} <= {1'b1, a, 1'b1};
    @(posedge clk);
    while (!arready) @(posedge clk);
    arvalid <= 1'b0;
    @(posedge clk);
    while (!rvalid) @(posedge clk);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk(d, exp, "read data");
    chk({30'h0, r}, {30'h0, er}, "read response");
  endtask
  task automatic t_reset;
    rd_chk(ADDR_ERR_ADDR, RESET_CAPTURE, RESP_OKAY);
    rd_chk(ADDR_ERR_UPPER, RESET_CAPTURE, RESP_OKAY);
    rd_chk(ADDR_ERR_LOWER, RESET_CAPTURE, RESP_OKAY);
    rd_chk(ADDR_CONTROL, 32'h0, RESP_OKAY);
    axi_write(ADDR_ERR_ADDR, 32'hFFFFFFFF, RESP_SLVERR);
    axi_write(ADDR_ERR_LOWER, 32'hFFFFFFFF, RESP_SLVERR);
    rd_chk(ADDR_ERR_ADDR, RESET_CAPTURE, RESP_OKAY);
    rd_chk(ADDR_ERR_LOWER, RESET_CAPTURE, RESP_OKAY);
    rd_chk(UNMAPPED, 32'h0, RESP_DECERR);
    $display("test reset values done");
  endtask
  task automatic t_selective;
    logic [31:0] d;
    logic [1:0] r;
    axi_write(ADDR_IRQ_ENABLE, 32'h1, RESP_OKAY);
    axi_write(ADDR_CONTROL, 32'h00000100, RESP_OKAY);
    cpu.tenure(32'h00001000, 5'h0A, 1'b0, 1'b1);
    cpu.beat(D1, 8'h01, 1'b0);
    cpu.tenure(32'h00002000, 5'h0E, 1'b1, 1'b0);
    cpu.beat(D1, 8'h01, 1'b0);
    rd_chk(ADDR_CONTROL, 32'h00000100, RESP_OKAY);
    cpu.tenure(32'h00002040, 5'h13, 1'b1, 1'b1);
    cpu.beat(D1, 8'h10, 1'b1);
    rd_chk(ADDR_CONTROL, 32'h00000100, RESP_OKAY);
    cpu.beat(D2, 8'h10, 1'b0);
    #1;
    chk({31'h0, machineCheckReqN}, 32'h0, "machine check low");
    chk({31'h0, irq}, 32'h1, "interrupt raised");
    @(posedge clk);
    #1;
    chk({31'h0, machineCheckReqN}, 32'h1, "machine check released");
    rd_chk(ADDR_CONTROL, {3'h4, 5'h13, cpu.goodPar(D2) ^ 8'h10, 16'h0100}, RESP_OKAY);
    rd_chk(ADDR_ERR_ADDR, 32'h00002040, RESP_OKAY);
    rd_chk(ADDR_ERR_UPPER, D2[63:32], RESP_OKAY);
    rd_chk(ADDR_ERR_LOWER, D2[31:0], RESP_OKAY);
    // A second error while logged must leave the captures alone
    cpu.beat(D1, 8'h02, 1'b0);
    rd_chk(ADDR_ERR_UPPER, D2[63:32], RESP_OKAY);
    rd_chk(ADDR_ERR_ADDR, 32'h00002040, RESP_OKAY);
    rd_chk(ADDR_IRQ_STATUS, 32'h3, RESP_OKAY);
    axi_write(ADDR_CONTROL, 32'h80000100, RESP_OKAY);
    axi_read(ADDR_CONTROL, d, r);
    chk({31'h0, d[CTL_LOGGED_BIT]}, 32'h0, "logged flag cleared");
    axi_write(ADDR_IRQ_CLEAR, 32'h3, RESP_OKAY);
    rd_chk(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "interrupt cleared");
    $display("test selective check done");
  endtask
  task automatic t_check_all;
    axi_write(ADDR_IRQ_ENABLE, 32'h0, RESP_OKAY);
    axi_write(ADDR_CONTROL, 32'h00000200, RESP_OKAY);
    cpu.tenure(32'h00003000, 5'h05, 1'b0, 1'b0);
    cpu.beat(D1, 8'h00, 1'b0);
    // Captured type and parity fields survive the clear of the logged flag
    rd_chk(ADDR_CONTROL, {3'h0, 5'h13, cpu.goodPar(D2) ^ 8'h10, 16'h0200}, RESP_OKAY);
    cpu.beat(D3, 8'h80, 1'b0);
    #1;
    chk({31'h0, machineCheckReqN}, 32'h1, "machine check disabled");
    rd_chk(ADDR_ERR_ADDR, 32'h00003000, RESP_OKAY);
    rd_chk(ADDR_ERR_LOWER, D3[31:0], RESP_OKAY);
    rd_chk(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "interrupt masked");
    $display("test check all done");
  endtask
  task automatic t_invert;
    for (int k = 0; k < LANES; k++) begin
      axi_write(ADDR_CONTROL, 32'h00000200 | (32'h1 << k), RESP_OKAY);
      @(posedge clk);
      {readDrive, readData} <= {1'b1, D2 ^ {8{8'(k)}}};
      @(posedge clk);
      readDrive <= 1'b0;
      #1;
      chk({31'h0, dpOe}, 32'h1, "parity drive enable");
      chk({24'h0, dpOut}, {24'h0, cpu.goodPar(D2 ^ {8{8'(k)}}) ^ (8'h1 << k)}, "driven parity");
    end
    $display("test parity invert done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_selective();
    t_check_all();
    t_invert();
    tally_and_finish();
  end
  // The whole sequence needs well under two thousand cycles
  initial begin
    #100000;
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule // testbench
